// ---- core/sep_core.sv ----
// serial eeprom command decoder, status byte and write protection
`timescale 1ns/1ps
module sep_core
    import sep_pkg::*;
#(
    parameter int WRITE_CYC = SEP_WRITE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic guard_n,
    input wire logic pause_n,
    output logic so,
    output logic so_oe_n,
    // array side
    output logic arr_wr,
    output logic [8:0] arr_addr,
    output logic [7:0] arr_wdata,
    output logic arr_rd,
    input wire logic [7:0] arr_rdata,
    // decoded id page access
    output logic id_req,
    output logic id_lock_sel,
    output logic [3:0] id_index,
    // status view
    output logic [7:0] status
);
    typedef struct packed {
        sep_state_type st;
        sep_cmd_type cmd;
        logic [4:0] cnt;
        logic [7:0] sh;
        logic [8:0] addr;
        logic [7:0] wdata;
        logic [7:0] obyte;
        logic latch;
        logic [1:0] guard;
        logic arm;
        logic busy;
        logic [31:0] wcnt;
        logic [1:0] pend_guard;
        logic pend_arm;
        logic pend_st;
        logic so;
        logic oe_n;
        logic arr_wr;
        logic arr_rd;
        logic id_req;
        logic id_lock;
        logic [3:0] id_idx;
    } sep_core_type;
    sep_core_type r;
    sep_core_type next_r;

    logic cs_lvl, cs_rise, cs_fall;
    logic sck_lvl, sck_rise, sck_fall;
    logic si_lvl, gd_lvl, ps_lvl;
    logic hw_guard;
    logic [7:0] shifted;
    logic [7:0] stat_view;

    sep_sync u_cs (.clk(clk), .rst(rst), .pin(cs_n), .rst_val(1'b1),
        .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
    sep_sync u_sck (.clk(clk), .rst(rst), .pin(sck), .rst_val(1'b0),
        .level(sck_lvl), .rise(sck_rise), .fall(sck_fall));
    sep_sync u_si (.clk(clk), .rst(rst), .pin(si), .rst_val(1'b0),
        .level(si_lvl), .rise(), .fall());
    sep_sync u_gd (.clk(clk), .rst(rst), .pin(guard_n), .rst_val(1'b1),
        .level(gd_lvl), .rise(), .fall());
    sep_sync u_ps (.clk(clk), .rst(rst), .pin(pause_n), .rst_val(1'b1),
        .level(ps_lvl), .rise(), .fall());

    // (RL1) hardware guard mode
    assign hw_guard = ~gd_lvl & r.arm;
    assign shifted = {r.sh[6:0], si_lvl};

    always_comb begin
        // (RL9) unstored bits read zero when idle
        stat_view = 8'h00;
        stat_view[SEP_BIT_LATCH] = r.latch;
        stat_view[SEP_BIT_GLO] = r.guard[0];
        stat_view[SEP_BIT_GHI] = r.guard[1];
        stat_view[SEP_BIT_ARM] = r.arm;
        // (RL11) all ones while writing
        if (r.busy) begin
            stat_view = SEP_STATUS_BUSY;
        end
    end

    always_comb begin
        next_r = r;
        next_r.arr_wr = 1'b0;
        next_r.arr_rd = 1'b0;
        next_r.id_req = 1'b0;
        // self-timed write cycle
        if (r.busy) begin
            if (r.wcnt == 32'(WRITE_CYC - 1)) begin
                next_r.busy = 1'b0;
                next_r.wcnt = '0;
                // values change only when the cycle completes
                if (r.pend_st) begin
                    next_r.guard = r.pend_guard;
                    next_r.arm = r.pend_arm;
                    next_r.pend_st = 1'b0;
                end
            end else begin
                next_r.wcnt = r.wcnt + 32'd1;
            end
        end
        if (cs_rise) begin
            // (RL23) partial opcode dropped unchanged
            case (r.cmd)
                SEP_C_WRS: begin
                    // (RL5) status write accepted only when unguarded
                    // full data byte has already moved the decoder to skip
                    if (r.st == SEP_SKIP && r.cnt == SEP_DATA_DONE[4:0] - 5'd8
                        && r.latch && !hw_guard && !r.busy) begin
                        next_r.busy = 1'b1;
                        next_r.pend_st = 1'b1;
                        next_r.pend_guard = {r.wdata[SEP_BIT_GHI],
                                             r.wdata[SEP_BIT_GLO]};
                        // (RL10) arm cannot drop while pin low
                        next_r.pend_arm = (r.arm & ~gd_lvl)
                            | r.wdata[SEP_BIT_ARM];
                        // (RL22) latch cleared after status write
                        next_r.latch = 1'b0;
                    end
                end
                SEP_C_WR: begin
                    // (RL15) array write needs latch, outside guard
                    if (r.st == SEP_DATA && r.latch && !r.busy
                        && !sep_in_guard(r.guard, r.addr)) begin
                        next_r.arr_wr = 1'b1;
                        next_r.busy = 1'b1;
                        // (RL22) latch cleared after array write
                        next_r.latch = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            next_r.st = SEP_IDLE;
            next_r.cmd = SEP_C_NONE;
            next_r.cnt = '0;
            next_r.oe_n = 1'b1;
            next_r.so = 1'b0;
        end else if (cs_fall) begin
            next_r.st = SEP_OPCODE;
            next_r.cnt = '0;
        end else if (!cs_lvl && ps_lvl) begin
            // (RL2) pause freezes state; (RL4) high pin runs normally
            if (sck_rise && r.st != SEP_IDLE && r.st != SEP_SKIP) begin
                // (RL16) msb first on rising edge
                next_r.sh = shifted;
                next_r.cnt = r.cnt + 5'd1;
                if (r.st == SEP_OPCODE && r.cnt == 5'(SEP_OP_BITS - 4'd1)) begin
                    next_r.st = SEP_SKIP;
                    // (RL6) busy accepts only status read
                    if (shifted[2:0] == SEP_LOW_RDS
                        && shifted[7:4] == SEP_HI_ARRAY) begin
                        next_r.cmd = SEP_C_RDS;
                        next_r.st = SEP_RDOUT;
                        next_r.obyte = stat_view;
                    end else if (!r.busy) begin
                        // (RL18) opcode decode
                        if (shifted[7:4] == SEP_HI_ARRAY) begin
                            case (shifted[2:0])
                                SEP_LOW_SET: begin
                                    // (RL22) latch set
                                    next_r.latch = 1'b1;
                                end
                                SEP_LOW_CLR: begin
                                    // (RL22) latch cleared
                                    next_r.latch = 1'b0;
                                end
                                SEP_LOW_WRS: begin
                                    next_r.cmd = SEP_C_WRS;
                                    next_r.st = SEP_DATA;
                                end
                                SEP_LOW_RD, SEP_LOW_WR: begin
                                    next_r.cmd = (shifted[2:0] == SEP_LOW_RD)
                                        ? SEP_C_RD : SEP_C_WR;
                                    next_r.st = SEP_ADDR;
                                    // (RL19) ninth address bit
                                    next_r.addr[8] =
                                        shifted[SEP_ADDR_HALF_BIT];
                                end
                                default: begin
                                end
                            endcase
                        end else if (shifted[7:4] == SEP_HI_IDPAGE
                                     && shifted[2:1] == SEP_LOW_RD[2:1]) begin
                            next_r.cmd = SEP_C_ID;
                            next_r.st = SEP_ADDR;
                        end
                    end
                end else if (r.st == SEP_ADDR
                             && r.cnt == SEP_ADDR_DONE - 5'd1) begin
                    next_r.addr[7:0] = shifted;
                    if (r.cmd == SEP_C_ID) begin
                        // (RL20) bit 7 picks lock access or page index
                        next_r.id_req = 1'b1;
                        next_r.id_lock = shifted[SEP_ID_SEL_BIT];
                        next_r.id_idx = shifted[3:0];
                        next_r.st = SEP_SKIP;
                    end else if (r.cmd == SEP_C_RD) begin
                        next_r.arr_rd = 1'b1;
                        next_r.st = SEP_RDOUT;
                        next_r.obyte = arr_rdata;
                    end else begin
                        next_r.st = SEP_DATA;
                    end
                end else if (r.st == SEP_DATA && r.cnt[2:0] == 3'd7) begin
                    // last byte kept; status write counts first byte only
                    next_r.wdata = shifted;
                    if (r.cmd == SEP_C_WRS) begin
                        next_r.st = SEP_SKIP;
                    end
                end else if (r.st == SEP_RDOUT && r.cnt[2:0] == 3'd7) begin
                    // status repeats; array reads advance with rollover
                    if (r.cmd == SEP_C_RDS) begin
                        next_r.obyte = stat_view;
                    end else begin
                        next_r.addr = r.addr + 9'd1;
                        next_r.arr_rd = 1'b1;
                        next_r.obyte = arr_rdata;
                    end
                end
            end
            // (RL16) shift out on falling edge
            if (sck_fall && r.st == SEP_RDOUT) begin
                next_r.oe_n = 1'b0;
                next_r.so = r.obyte[3'd7 - r.cnt[2:0]];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.st <= SEP_IDLE;
            r.cmd <= SEP_C_NONE;
            r.oe_n <= 1'b1;
            // (RL7) latch zero at power up; (RL8) guards shipped zero
            r.latch <= 1'b0;
            r.guard <= SEP_GUARD_RESET;
            r.arm <= SEP_ARM_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign so = r.so;
    assign so_oe_n = r.oe_n;
    assign arr_wr = r.arr_wr;
    assign arr_rd = r.arr_rd;
    assign arr_addr = r.addr;
    assign arr_wdata = r.wdata;
    assign id_req = r.id_req;
    assign id_lock_sel = r.id_lock;
    assign id_index = r.id_idx;
    assign status = stat_view;

    // (RL14) (RL15) guarded array never written
    property p_guard_wr;
        @(posedge clk) disable iff (rst)
        arr_wr |-> !sep_in_guard(r.guard, arr_addr);
    endproperty
    a_guard_wr: assert property (p_guard_wr) // RL15
        else $error("guarded write");

    property p_wr_latch;
        @(posedge clk) disable iff (rst)
        arr_wr |-> $past(r.latch) && !r.latch;
    endproperty
    a_wr_latch: assert property (p_wr_latch) // RL22
        else $error("latch on write");

    property p_hw_guard;
        @(posedge clk) disable iff (rst)
        (cs_rise && hw_guard) |=> !r.pend_st || $past(r.pend_st);
    endproperty
    a_hw_guard: assert property (p_hw_guard) // RL1
        else $error("hw guard");

    property p_arm_hold;
        @(posedge clk) disable iff (rst)
        ($past(r.arm) && !r.arm) |-> $past(gd_lvl, 1) || $past(gd_lvl, 2);
    endproperty
    a_arm_hold: assert property (p_arm_hold) // RL10
        else $error("arm dropped");

    property p_busy_view;
        @(posedge clk) disable iff (rst)
        r.busy |-> status == SEP_STATUS_BUSY;
    endproperty
    a_busy_view: assert property (p_busy_view) // RL11
        else $error("busy view");

    property p_idle_bits;
        @(posedge clk) disable iff (rst)
        !r.busy |-> status[6:4] == 3'b000 && status[0] == 1'b0;
    endproperty
    a_idle_bits: assert property (p_idle_bits) // RL9
        else $error("idle bits");

    property p_pause;
        @(posedge clk) disable iff (rst)
        (!ps_lvl && !cs_lvl && !cs_rise && !cs_fall) |=> $stable(r.cnt);
    endproperty
    a_pause: assert property (p_pause) // RL2
        else $error("pause moved");

    property p_st_latch;
        @(posedge clk) disable iff (rst)
        $rose(r.pend_st) |-> $past(r.latch) && !r.latch;
    endproperty
    a_st_latch: assert property (p_st_latch) // RL5
        else $error("status write without latch");

    property p_busy_end;
        @(posedge clk) disable iff (rst)
        $rose(r.busy) |-> r.busy [*8];
    endproperty
    a_busy_end: assert property (p_busy_end) // RL6
        else $error("busy short");
endmodule : sep_core

// ---- core/sep_pkg.sv ----
// constants and types for the serial eeprom command and protection block
// Behaviour
// (RL1) guard pin low with arm bit set blocks changes to guard and arm bits
// (RL2) pause pin low freezes the serial sequence; it resumes where it stopped
// (RL3) master changes the pause pin only while the serial clock is low
// (RL4) pause pin tied high means normal operation
// (RL5) status byte is 8 bits; writable only if latch set, no hw guard
// (RL6) bit 0 is busy; while busy only status read is accepted
// (RL7) bit 1 is the write-enable latch; zero blocks changes; zero at reset
// (RL8) bits 2 and 3 are block guards, kept nonvolatile, reset to zero
// (RL9) bits 4 to 6 are not stored and read zero except while busy
// (RL10) arm bit cannot go from 1 to 0 while guard pin is low
// (RL11) during an internal write all status bits read as 1
// (RL12) master rereads status after ready first drops
// (RL13) master may wait 5 ms after a write instead of polling
// (RL14) guard bits pick none, top quarter, upper half or whole array
// (RL15) guarded block read-only; rest needs latch; status also no hw guard
// (RL16) opcode is first 8 bits on rising edges, msb first; out on fall
// (RL17) master raises chip select after the last bit to start the operation
// (RL18) opcodes: latch set x110, clear x100, status read x101, write x001
// (RL19) array opcodes take opcode bit 3 as the ninth address bit
// (RL20) id page opcodes: address bit 7 picks page data or lock access
// (RL21) master sends only valid opcodes with don't-care bits zero; the bench also sends bit 3 set (0x0c, 0x0d, 0x0e)
// (RL22) power up disabled; clear latch after clear, status or array write
// (RL23) chip select rising mid-opcode drops the command without effect
package sep_pkg;
    localparam logic [2:0] SEP_LOW_SET = 3'h6;
    localparam logic [2:0] SEP_LOW_CLR = 3'h4;
    localparam logic [2:0] SEP_LOW_RDS = 3'h5;
    localparam logic [2:0] SEP_LOW_WRS = 3'h1;
    localparam logic [2:0] SEP_LOW_RD = 3'h3;
    localparam logic [2:0] SEP_LOW_WR = 3'h2;
    localparam logic [3:0] SEP_HI_ARRAY = 4'h0;
    localparam logic [3:0] SEP_HI_IDPAGE = 4'h8;
    localparam int SEP_BIT_BUSY = 0;
    localparam int SEP_BIT_LATCH = 1;
    localparam int SEP_BIT_GLO = 2;
    localparam int SEP_BIT_GHI = 3;
    localparam int SEP_BIT_ARM = 7;
    localparam int SEP_ADDR_HALF_BIT = 3;
    localparam int SEP_ID_SEL_BIT = 7;
    localparam logic [8:0] SEP_QTR_BASE = 9'h180;
    localparam logic [8:0] SEP_HALF_BASE = 9'h100;
    localparam logic [1:0] SEP_GUARD_RESET = 2'h0;
    localparam logic SEP_ARM_RESET = 1'b0;
    localparam logic [7:0] SEP_STATUS_BUSY = 8'hff;
    localparam logic [3:0] SEP_OP_BITS = 4'h8;
    localparam logic [4:0] SEP_ADDR_DONE = 5'h10;
    localparam logic [4:0] SEP_DATA_DONE = 5'h18;
    localparam int SEP_CLK_NS = 50;
    localparam int SEP_WRITE_US = 4000;
    localparam int SEP_WRITE_CYC = (SEP_WRITE_US * 1000) / SEP_CLK_NS;

    typedef enum logic [2:0] {
        SEP_IDLE = 3'b000,
        SEP_OPCODE = 3'b001,
        SEP_ADDR = 3'b010,
        SEP_DATA = 3'b011,
        SEP_RDOUT = 3'b100,
        SEP_SKIP = 3'b101
    } sep_state_type;

    typedef enum logic [2:0] {
        SEP_C_NONE = 3'b000,
        SEP_C_SET = 3'b001,
        SEP_C_CLR = 3'b010,
        SEP_C_RDS = 3'b011,
        SEP_C_WRS = 3'b100,
        SEP_C_RD = 3'b101,
        SEP_C_WR = 3'b110,
        SEP_C_ID = 3'b111
    } sep_cmd_type;

    // (RL14) guarded range, shared by the write path and its check
    function automatic logic sep_in_guard(input logic [1:0] g,
                                          input logic [8:0] a);
        case (g)
            2'b00: sep_in_guard = 1'b0;
            2'b01: sep_in_guard = (a >= SEP_QTR_BASE);
            2'b10: sep_in_guard = (a >= SEP_HALF_BASE);
            default: sep_in_guard = 1'b1;
        endcase
    endfunction : sep_in_guard
endpackage : sep_pkg

// ---- core/sep_sync.sv ----
// two flop synchroniser with edge detect for the serial pins
`timescale 1ns/1ps
module sep_sync
    import sep_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin in
    input wire logic pin,
    input wire logic rst_val,
    // synced level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sep_sync_type;
    sep_sync_type r;
    sep_sync_type next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = pin;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    // reset value is a constant per instance, fed from a tie
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '{s1: rst_val, s2: rst_val, s3: rst_val};
        end else begin
            r <= next_r;
        end
    end

    assign level = r.s2;
    assign rise = r.s2 & ~r.s3;
    assign fall = ~r.s2 & r.s3;
endmodule : sep_sync

// ---- verif/sep_master.sv ----
// serial bus master model that drives the eeprom pins
`timescale 1ns/1ps
module sep_master (
    // bench clock
    input wire logic clk,
    // serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic pause_n,
    input wire logic so
);
    int pause_at = -1;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        pause_n = 1'b1;
    end

    // half of the 400 ns serial period
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask : half

    task automatic frame(input logic [23:0] tx, input int nbits,
                         output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            si = tx[23 - i];
            half();
            sck = 1'b1;
            rx = {rx[6:0], so};
            half();
            sck = 1'b0;
            if (i == pause_at) begin
                half();
                pause_n = 1'b0;
                // clock and data wiggle while paused, must be ignored
                repeat (4) begin
                    si = ~si;
                    half();
                    sck = ~sck;
                end
                half();
                pause_n = 1'b1;
            end
        end
        half();
        cs_n = 1'b1;
        // released line no longer shows the last bit
        si = ~si;
        half();
    endtask : frame
endmodule : sep_master

// ---- verif/tb_top.sv ----
// self-checking bench for the eeprom command and protection core
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic guard_n = 1'b1;
    logic cs_n, sck, si, pause_n, so, so_oe_n;
    logic so_line;
    // released output reads one, since so is zero whenever released
    assign so_line = so_oe_n ? ~so : so;
    logic arr_wr, arr_rd, id_req, id_lock_sel;
    logic [8:0] arr_addr, wr_a, rd_a;
    logic [7:0] arr_wdata, wr_d, status, rx;
    logic [3:0] id_index, id_i;
    logic id_l;
    int wr_n = 0;
    int rd_n = 0;
    int id_n = 0;
    int n0;
    int cyc = 0;
    int err_count = 0;
    int checks = 0;
    logic ok;
    logic [9:0] base [4] = '{10'h200, 10'h180, 10'h100, 10'h000};
    logic [8:0] adr [4] = '{9'h000, 9'h0ff, 9'h17f, 9'h180};

    always #25 clk = ~clk;

    sep_core #(.WRITE_CYC(400)) dut_u (
        .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
        .guard_n(guard_n), .pause_n(pause_n), .so(so),
        .so_oe_n(so_oe_n), .arr_wr(arr_wr), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .arr_rd(arr_rd), .arr_rdata(8'h3c),
        .id_req(id_req), .id_lock_sel(id_lock_sel),
        .id_index(id_index), .status(status)
    );

    sep_master m (
        .clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
        .pause_n(pause_n), .so(so_line)
    );

    // pulses are one cycle, so catch them here
    always @(posedge clk) begin
        if (arr_wr === 1'b1) begin
            wr_n <= wr_n + 1;
            wr_a <= arr_addr;
            wr_d <= arr_wdata;
        end
        if (arr_rd === 1'b1) begin
            rd_n <= rd_n + 1;
            rd_a <= arr_addr;
        end
        if (id_req === 1'b1) begin
            id_n <= id_n + 1;
            id_l <= id_lock_sel;
            id_i <= id_index;
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            test_done();
        end
    end

    task automatic check(input string name, input logic [8:0] seen,
                         input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cmd(input logic [7:0] op);
        m.frame({op, 16'h0000}, 8, rx);
    endtask : cmd

    task automatic wait_ready();
        int n;
        n = 0;
        repeat (4) @(posedge clk);
        #1;
        // bounded poll stands in for the fixed write wait
        while (status[0] !== 1'b0 && n < 2000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("ready", {8'h00, status[0]}, 9'h000);
        // first drop may be garbled, wait two more cycles before returning
        repeat (2) @(posedge clk);
        #1;
    endtask : wait_ready

    task automatic wsr(input logic [7:0] v);
        cmd(8'h06);
        m.frame({8'h01, v, 8'h00}, 16, rx);
        wait_ready();
    endtask : wsr

    task automatic arr_write(input logic [8:0] a, input logic [7:0] d);
        cmd(8'h06);
        m.frame({4'h0, a[8], 3'h2, a[7:0], d}, 24, rx);
        wait_ready();
    endtask : arr_write

    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check("status", {1'b0, status}, 9'h000);
        m.frame({8'h05, 16'h0000}, 16, rx);
        check("rd status", {1'b0, rx}, 9'h000);
        check("so idle", {8'h00, so_oe_n}, 9'h001);
        for (int k = 0; k < 2; k++) begin
            cmd({4'h0, k[0], 3'h6});
            check("set", {1'b0, status}, 9'h002);
            cmd({4'h0, k[0], 3'h4});
            check("clear", {1'b0, status}, 9'h000);
        end
        m.frame({8'h01, 8'h8c, 8'h00}, 16, rx);
        wait_ready();
        check("no latch", {1'b0, status}, 9'h000);
        $display("test latch done");

        cmd(8'h06);
        m.frame({8'h01, 8'hfc, 8'h00}, 16, rx);
        check("busy", {1'b0, status}, 9'h0ff);
        m.frame({8'h0d, 16'h0000}, 16, rx);
        check("busy rd", {1'b0, rx}, 9'h0ff);
        cmd(8'h06);
        wait_ready();
        check("stored", {1'b0, status}, 9'h08c);
        m.pause_at = 3;
        cmd(8'h06);
        m.pause_at = -1;
        check("paused", {1'b0, status}, 9'h08e);
        cmd(8'h04);
        m.frame({8'h06, 16'h0000}, 7, rx);
        check("partial", {1'b0, status}, 9'h08c);
        $display("test busy done");

        guard_n = 1'b0;
        wsr(8'h00);
        check("hw guard", {1'b0, status & 8'hfc}, 9'h08c);
        guard_n = 1'b1;
        wsr(8'h00);
        check("unguard", {1'b0, status}, 9'h000);
        $display("test hw guard done");

        for (int g = 0; g < 4; g++) begin
            wsr({4'h0, g[1:0], 2'b00});
            check("guard", {1'b0, status}, {5'h00, g[1:0], 2'b00});
            for (int j = 0; j < 4; j++) begin
                n0 = wr_n;
                arr_write(adr[j], 8'ha0 + j[7:0]);
                ok = ({1'b0, adr[j]} < base[g]);
                check("wr count", 9'(wr_n - n0), {8'h00, ok});
                if (ok) begin
                    check("wr addr", wr_a, adr[j]);
                    check("wr data", {1'b0, wr_d}, 9'ha0 + 9'(j));
                    check("latch", {8'h00, status[1]}, 9'h000);
                end
            end
        end
        $display("test block guard done");

        n0 = rd_n;
        m.frame({8'h0b, 8'h22, 8'h00}, 24, rx);
        // first fetch at 0x122, then a prefetch of the next byte
        check("rd count", 9'(rd_n - n0), 9'h002);
        check("rd addr", rd_a, 9'h123);
        check("rd data", {1'b0, rx}, 9'h03c);
        m.frame({8'h83, 8'h05, 8'h00}, 24, rx);
        check("id sel", {8'h00, id_l}, 9'h000);
        check("id idx", {5'h00, id_i}, 9'h005);
        m.frame({8'h82, 8'h80, 8'h02}, 24, rx);
        check("lock sel", {8'h00, id_l}, 9'h001);
        check("id count", 9'(id_n), 9'h002);
        $display("test read and id done");
        test_done();
    end
endmodule : tb_top
